// ---- logic/flsp_link.sv ----
/*
 * flsp_link: serial front end. Synchronises clock, select, data-in and the
 * write-protect pin to clk_sys_i, finds clock edges, assembles bytes (mode 0,
 * MSB first) and shifts status bytes out on falling edges.
 * Assumes the serial clock is much slower than clk_sys_i (8 samples a period).
 */
`timescale 1ns/100ps
module flsp_link
    import flsp_pkg::*;
(
    input  wire logic   clk_sys_i,        // system clock
    input  wire logic   sys_rst_i,        // sync reset, active high
    input  wire logic   spi_sclk_i,       // serial clock pin
    input  wire logic   spi_cs_n_i,       // chip select pin, active low
    input  wire logic   spi_mosi_i,       // serial data in pin
    input  wire logic   wp_n_i,           // write-protect pin, active low
    output logic        spi_miso_o,       // serial data out
    output logic        spi_miso_oe_n_o,  // data out enable, active low
    flsp_link_if.link   lnk               // byte side
);

    typedef struct packed {
        logic       sclk_s1;
        logic       sclk_s2;
        logic       sclk_d;
        logic       cs_s1;
        logic       cs_s2;
        logic       cs_d;
        logic       mosi_s1;
        logic       mosi_s2;
        logic       wp_s1;
        logic       wp_s2;
        logic [2:0] bit_cnt;
        logic [7:0] rx_sh;
        logic [7:0] tx_sh;
        logic       start_p;
        logic       end_p;
        logic       byte_p;
    } flsp_link_s;

    flsp_link_s q;
    flsp_link_s next_q;
    logic       rise;
    logic       fall;

    // edges only from the second stage; first stages feed nothing else
    assign rise = q.sclk_s2 & ~q.sclk_d;
    assign fall = ~q.sclk_s2 & q.sclk_d;

    always_comb begin
        next_q         = q;
        next_q.sclk_s1 = spi_sclk_i;
        next_q.sclk_s2 = q.sclk_s1;
        next_q.sclk_d  = q.sclk_s2;
        next_q.cs_s1   = spi_cs_n_i;
        next_q.cs_s2   = q.cs_s1;
        next_q.cs_d    = q.cs_s2;
        next_q.mosi_s1 = spi_mosi_i;
        next_q.mosi_s2 = q.mosi_s1;
        next_q.wp_s1   = wp_n_i;
        next_q.wp_s2   = q.wp_s1;
        next_q.start_p = q.cs_d & ~q.cs_s2;
        next_q.end_p   = ~q.cs_d & q.cs_s2;
        next_q.byte_p  = 1'b0;
        if (q.cs_d & ~q.cs_s2) begin
            next_q.bit_cnt = 3'h0;
        end else if (~q.cs_s2 & rise) begin
            next_q.rx_sh   = {q.rx_sh[6:0], q.mosi_s2};
            next_q.bit_cnt = q.bit_cnt + 3'h1;
            next_q.byte_p  = (q.bit_cnt == 3'h7);
        end
        // load at a boundary so the msb is out before the host samples it
        if (~q.cs_s2 & fall) begin
            if (q.bit_cnt == 3'h0) begin
                next_q.tx_sh = lnk.tx_byte;
            end else begin
                next_q.tx_sh = {q.tx_sh[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            q         <= '0;
            q.sclk_s1 <= 1'b0;
            q.cs_s1   <= 1'b1;
            q.cs_s2   <= 1'b1;
            q.cs_d    <= 1'b1;
            q.wp_s1   <= 1'b1;
            q.wp_s2   <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    assign lnk.frame_start = q.start_p;
    assign lnk.frame_end   = q.end_p;
    assign lnk.byte_valid  = q.byte_p;
    assign lnk.aligned     = (q.bit_cnt == 3'h0);
    assign lnk.rx_byte     = q.rx_sh;
    assign lnk.wp_level    = q.wp_s2;
    assign spi_miso_o      = q.tx_sh[7];
    assign spi_miso_oe_n_o = ~(lnk.tx_en & ~q.cs_s2);

endmodule : flsp_link

// ---- logic/flsp_link_if.sv ----
/*
 * flsp_link_if: byte-level carrier between the serial front end and the
 * status/protect core. All signals are on clk_sys_i; pulses last one cycle.
 */
`timescale 1ns/100ps
interface flsp_link_if;
    logic       frame_start;   // chip select fell
    logic       frame_end;     // chip select rose
    logic       byte_valid;    // eighth bit of a byte taken
    logic       aligned;       // bit counter on a byte boundary
    logic [7:0] rx_byte;       // byte just taken
    logic       wp_level;      // write-protect pin, synchronised
    logic [7:0] tx_byte;       // byte to shift out next
    logic       tx_en;         // drive the data-out pin

    modport link (output frame_start, frame_end, byte_valid, aligned, rx_byte, wp_level,
                  input  tx_byte, tx_en);
    modport core (input  frame_start, frame_end, byte_valid, aligned, rx_byte, wp_level,
                  output tx_byte, tx_en);
endinterface : flsp_link_if

// ---- logic/flsp_pkg.sv ----
/*
 * flsp_pkg: shared constants and types for the serial flash status and
 * write-protect block: status bit positions, power-up values, opcodes,
 * array operation kinds and timing counts.
 * Assumes a 10 MHz system clock; every user of this package imports it whole.
 */
package flsp_pkg;

    // system clock
    localparam int unsigned CLK_PERIOD_NS  = 100;

    // status write busy time (no figure given, plain default)
    localparam int unsigned WRSR_TIME_NS   = 5000;
    localparam int unsigned WRSR_CYCLES    = (WRSR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TMR_W          = 8;
    localparam logic [TMR_W-1:0] WRSR_LOAD = TMR_W'(WRSR_CYCLES);

    // status bit positions
    localparam int unsigned SR_STATUS_WRITE_DISABLE        = 7;
    localparam int unsigned SR_PFAIL       = 6;
    localparam int unsigned SR_EFAIL       = 5;
    localparam int unsigned SR_BP_HI       = 4;
    localparam int unsigned SR_BP_LO       = 2;
    localparam int unsigned SR_WEL         = 1;
    localparam int unsigned SR_WIP         = 0;

    // power-up values
    localparam logic        STATUS_WRITE_DISABLE_RST       = 1'b0;
    localparam logic        PFAIL_RST      = 1'b0;
    localparam logic        EFAIL_RST      = 1'b0;
    localparam logic [2:0]  BP_RST         = 3'h7;
    localparam logic        WEL_RST        = 1'b0;
    localparam logic        WIP_RST        = 1'b0;

    // protect-level codes
    localparam logic [2:0]  BP_NONE        = 3'h0;
    localparam logic [2:0]  BP_HALF        = 3'h6;
    localparam logic [2:0]  BP_ALL         = 3'h7;

    // opcodes
    localparam logic [7:0]  OPC_WRSR       = 8'h01;
    localparam logic [7:0]  OPC_PP         = 8'h02;
    localparam logic [7:0]  OPC_WRDI       = 8'h04;
    localparam logic [7:0]  OPC_RDSR       = 8'h05;
    localparam logic [7:0]  OPC_WREN       = 8'h06;
    localparam logic [7:0]  OPC_CLRF       = 8'h30;
    localparam logic [7:0]  OPC_PBE        = 8'h40;
    localparam logic [7:0]  OPC_OTP        = 8'h42;
    localparam logic [7:0]  OPC_BE         = 8'hc7;
    localparam logic [7:0]  OPC_SE         = 8'hd8;

    // frame byte counts (opcode included)
    localparam logic [2:0]  CNT_OPC_ONLY   = 3'h1;
    localparam logic [2:0]  CNT_WRSR       = 3'h2;
    localparam logic [2:0]  CNT_ADDR       = 3'h4;
    localparam logic [2:0]  CNT_ONE_DATA   = 3'h5;
    localparam logic [2:0]  CNT_MAX        = 3'h7;

    // address layout
    localparam int unsigned SECTOR_LSB     = 16;
    localparam int unsigned DEFAULT_SECTORS = 128;

    // array operation handed to the sequencer
    typedef enum logic [2:0] {
        OP_PAGE,
        OP_OTP,
        OP_SECT,
        OP_PARAM,
        OP_BULK
    } flsp_op_e;

    // what keeps the busy bit high
    typedef enum logic [1:0] {
        BZ_IDLE,
        BZ_WRSR,
        BZ_ARRAY
    } flsp_busy_e;

endpackage : flsp_pkg

// ---- logic/flsp_status.sv ----
/*
 * flsp_status: status register and main-array write protection of a serial
 * flash. Decodes the commands that touch status, checks program and erase
 * targets against the protect level, and hands allowed operations to an
 * external array sequencer, which answers with done and fail.
 * Assumes the sequencer raises op_done_i once per op_start_o and that the
 * serial link is slow against clk_sys_i.
 */
`timescale 1ns/100ps
// Function
// - write-disable set and pin low: write-disable and protect bits refuse change
// - power-up: write-disable, fail flags, latch, busy read 0; protect bits 1
// - program fail flag sets on failed or protected program
// - program fail flag untouched for botched frame or latch clear
// - program fail flag accumulates until explicitly cleared
// - erase fail flag sets on failed or protected erase
// - erase fail flag untouched for botched frame or latch clear
// - erase fail flag stays set until the clear-fail command
// - status writes leave fail flags; clear-fail works in every mode
// - protect code selects contiguous top sectors; zero protects none
// - 128 sectors: codes 1..7 protect top 2,4,8,16,32,64, all
// - 64 and 32 sector maps for codes 1..5; code 7 protects all
// - latch needed for writes; clears on completion, kept on botch
// - only write-enable sets the latch; write-disable, completion or a refused protected write clear it
// - busy bit high during program, erase or status write
// - hardware protect locks protected bits until pin high or power-up
// - otherwise software protect: write-disable and protect bits writable
// - array permission comes only from protect bits (and bottom sector for parameter erase); the pin plays no part
// - opcode 06h sets the write-enable latch
// - opcode 30h runs without the latch and leaves it alone
// - while busy only read-status is recognised
module flsp_status
    import flsp_pkg::*;
#(
    parameter int unsigned SECTORS = DEFAULT_SECTORS   // 128, 64 or 32
)(
    input  wire logic        clk_sys_i,        // system clock, 10 MHz
    input  wire logic        sys_rst_i,        // sync reset, active high
    input  wire logic        spi_sclk_i,       // serial clock pin
    input  wire logic        spi_cs_n_i,       // chip select, active low
    input  wire logic        spi_mosi_i,       // serial data in
    output logic             spi_miso_o,       // serial data out
    output logic             spi_miso_oe_n_o,  // data out enable, active low
    input  wire logic        wp_n_i,           // write-protect pin, active low
    output logic             op_start_o,       // one-cycle array start pulse
    output flsp_op_e         op_kind_o,        // kind of array operation
    output logic [23:0]      op_addr_o,        // target address
    input  wire logic        op_done_i,        // array operation finished
    input  wire logic        op_fail_i,        // with op_done_i: it failed
    output logic [7:0]       status_reg_o,     // live status value
    output logic             hw_protect_o      // hardware protect mode active
);

    typedef struct packed {
        logic        status_write_disable;
        logic        pfail;
        logic        efail;
        logic [2:0]  protect_level;
        logic        write_enable_latch;
        logic        write_in_progress;
        flsp_busy_e  busy;
        logic [TMR_W-1:0] timer;
        logic [7:0]  opcode;
        logic [2:0]  byte_cnt;
        logic [23:0] addr;
        logic [7:0]  data;
        logic        start;
        flsp_op_e    kind;
    } flsp_core_s;

    flsp_core_s  q;
    flsp_core_s  next_q;
    logic [7:0]  status_reg;
    logic        hw_lock;
    logic        addr_prot;
    logic        param_ok;

    flsp_link_if lnk ();

    flsp_link u_link (
        .clk_sys_i       (clk_sys_i),
        .sys_rst_i       (sys_rst_i),
        .spi_sclk_i      (spi_sclk_i),
        .spi_cs_n_i      (spi_cs_n_i),
        .spi_mosi_i      (spi_mosi_i),
        .wp_n_i          (wp_n_i),
        .spi_miso_o      (spi_miso_o),
        .spi_miso_oe_n_o (spi_miso_oe_n_o),
        .lnk             (lnk)
    );

    // true when the sector lies in the protected top group
    function automatic logic sector_hit(input logic [2:0] code, input logic [7:0] sec);
        int n;
        n = 0;
        if (code == BP_NONE) begin
            return 1'b0;
        end
        if (code == BP_ALL) begin
            return 1'b1;
        end
        if (SECTORS == 32) begin
            if (code == BP_HALF) begin
                return 1'b1;
            end
            n = SECTORS >> (6 - int'(code));
        end else begin
            n = SECTORS >> (7 - int'(code));
        end
        return int'(sec) >= (SECTORS - n);
    endfunction : sector_hit

    // sector field masked to the density; upper bits alias as in a real part
    assign addr_prot  = sector_hit(q.protect_level,
                                   q.addr[SECTOR_LSB +: 8] & 8'(SECTORS - 1));
    // parameter blocks sit in the bottom sector
    assign param_ok   = ((q.addr[SECTOR_LSB +: 8] & 8'(SECTORS - 1)) == 8'h00);

    // hardware protect: pin low with the write-disable bit set
    assign hw_lock    = q.status_write_disable & ~lnk.wp_level;

    assign status_reg = {q.status_write_disable, q.pfail, q.efail, q.protect_level,
                         q.write_enable_latch, q.write_in_progress};

    always_comb begin
        next_q       = q;
        next_q.start = 1'b0;

        // byte assembly within a frame
        if (lnk.frame_start) begin
            next_q.byte_cnt = 3'h0;
        end else if (lnk.byte_valid) begin
            if (q.byte_cnt == 3'h0) begin
                next_q.opcode = lnk.rx_byte;
            end else if (q.byte_cnt < CNT_ADDR) begin
                next_q.addr = {q.addr[15:0], lnk.rx_byte};
            end
            if (q.byte_cnt == 3'h1) begin
                next_q.data = lnk.rx_byte;
            end
            if (q.byte_cnt != CNT_MAX) begin
                next_q.byte_cnt = q.byte_cnt + 3'h1;
            end
        end

        // commands act at the rising select edge; botched frames do nothing
        if (lnk.frame_end && lnk.aligned && !q.write_in_progress) begin
            case (q.opcode)
                OPC_WREN: begin
                    if (q.byte_cnt == CNT_OPC_ONLY) begin
                        next_q.write_enable_latch = 1'b1;
                    end
                end
                OPC_WRDI: begin
                    if (q.byte_cnt == CNT_OPC_ONLY) begin
                        next_q.write_enable_latch = 1'b0;
                    end
                end
                OPC_CLRF: begin
                    // no latch needed and the latch is left as it is
                    if (q.byte_cnt == CNT_OPC_ONLY) begin
                        next_q.pfail = 1'b0;
                        next_q.efail = 1'b0;
                    end
                end
                OPC_WRSR: begin
                    if (q.write_enable_latch && q.byte_cnt >= CNT_WRSR) begin
                        // fail flags and latch are never written from the data byte
                        if (!hw_lock) begin
                            next_q.status_write_disable = q.data[SR_STATUS_WRITE_DISABLE];
                            next_q.protect_level        = q.data[SR_BP_HI:SR_BP_LO];
                        end
                        next_q.write_in_progress = 1'b1;
                        next_q.busy              = BZ_WRSR;
                        next_q.timer             = WRSR_LOAD;
                    end
                end
                OPC_PP: begin
                    if (q.write_enable_latch && q.byte_cnt >= CNT_ONE_DATA) begin
                        if (addr_prot) begin
                            next_q.pfail              = 1'b1;
                            next_q.write_enable_latch = 1'b0;
                        end else begin
                            next_q.start = 1'b1;
                            next_q.kind  = OP_PAGE;
                        end
                    end
                end
                OPC_OTP: begin
                    // exactly one data byte; lock and address are the sequencer's check
                    if (q.write_enable_latch && q.byte_cnt == CNT_ONE_DATA) begin
                        next_q.start = 1'b1;
                        next_q.kind  = OP_OTP;
                    end
                end
                OPC_SE, OPC_PBE: begin
                    if (q.write_enable_latch && q.byte_cnt == CNT_ADDR) begin
                        if (addr_prot || (q.opcode == OPC_PBE && !param_ok)) begin
                            next_q.efail              = 1'b1;
                            next_q.write_enable_latch = 1'b0;
                        end else begin
                            next_q.start = 1'b1;
                            next_q.kind  = (q.opcode == OPC_SE) ? OP_SECT : OP_PARAM;
                        end
                    end
                end
                OPC_BE: begin
                    if (q.write_enable_latch && q.byte_cnt == CNT_OPC_ONLY) begin
                        // any protected sector refuses the whole erase
                        if (q.protect_level != BP_NONE) begin
                            next_q.efail              = 1'b1;
                            next_q.write_enable_latch = 1'b0;
                        end else begin
                            next_q.start = 1'b1;
                            next_q.kind  = OP_BULK;
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        // an accepted array operation keeps the busy bit up until done
        if (next_q.start) begin
            next_q.write_in_progress = 1'b1;
            next_q.busy              = BZ_ARRAY;
        end

        // completion; fail flags only ever or-in here
        case (q.busy)
            BZ_WRSR: begin
                if (q.timer <= TMR_W'(1)) begin
                    next_q.write_in_progress  = 1'b0;
                    next_q.write_enable_latch = 1'b0;
                    next_q.busy               = BZ_IDLE;
                end else begin
                    next_q.timer = q.timer - TMR_W'(1);
                end
            end
            BZ_ARRAY: begin
                if (op_done_i) begin
                    next_q.write_in_progress  = 1'b0;
                    next_q.write_enable_latch = 1'b0;
                    next_q.busy               = BZ_IDLE;
                    if (op_fail_i && (q.kind == OP_PAGE || q.kind == OP_OTP)) begin
                        next_q.pfail = 1'b1;
                    end
                    if (op_fail_i && (q.kind == OP_SECT || q.kind == OP_PARAM || q.kind == OP_BULK)) begin
                        next_q.efail = 1'b1;
                    end
                end
            end
            BZ_IDLE: begin
            end
            default: begin
                next_q.busy = BZ_IDLE;
            end
        endcase
    end

    // nothing is kept across power loss: reset is power-up
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            q                      <= '0;
            q.status_write_disable <= STATUS_WRITE_DISABLE_RST;
            q.pfail                <= PFAIL_RST;
            q.efail                <= EFAIL_RST;
            q.protect_level        <= BP_RST;
            q.write_enable_latch   <= WEL_RST;
            q.write_in_progress    <= WIP_RST;
            q.busy                 <= BZ_IDLE;
            q.kind                 <= OP_PAGE;
        end else begin
            q <= next_q;
        end
    end

    // status byte is reloaded at every byte boundary, so polling sees live busy
    assign lnk.tx_byte   = status_reg;
    assign lnk.tx_en     = (q.opcode == OPC_RDSR) && (q.byte_cnt != 3'h0);

    assign op_start_o    = q.start;
    assign op_kind_o     = q.kind;
    assign op_addr_o     = q.addr;
    assign status_reg_o  = status_reg;
    assign hw_protect_o  = hw_lock;

endmodule : flsp_status

// ---- testbench/flsp_asserts.sv ----
/* flsp_asserts: port checks for the status and protect block.
   Assumes one clock domain and a sequencer that answers array ops only. */
`timescale 1ns/100ps
module flsp_asserts
    import flsp_pkg::*;
(
    input  wire logic       clk_sys_i,    // system clock
    input  wire logic       sys_rst_i,    // sync reset
    input  wire logic       op_start_o,   // array start
    input  wire flsp_op_e   op_kind_o,    // array op kind
    input  wire logic       op_done_i,    // sequencer done
    input  wire logic       op_fail_i,    // sequencer fail
    input  wire logic [7:0] status_reg_o, // status value
    input  wire logic       hw_protect_o  // hardware protect
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    // array completion while busy, and its failing-program case
    sequence s_done; op_done_i && status_reg_o[0]; endsequence
    sequence s_pfail; s_done ##0 (op_fail_i && (op_kind_o inside {OP_PAGE, OP_OTP})); endsequence
    // status relations, each tied to its cause
    property p_rst; $fell(sys_rst_i) |-> status_reg_o == 8'h1c && !hw_protect_o; endproperty
    a_rst: assert property (p_rst) else $error("power-up status wrong");
    property p_pset; s_pfail |=> status_reg_o[6]; endproperty
    a_pset: assert property (p_pset) else $error("program fail not flagged");
    property p_phold; status_reg_o[6] && status_reg_o[0] |=> status_reg_o[6]; endproperty
    a_phold: assert property (p_phold) else $error("program fail flag lost");
    property p_ehold; status_reg_o[5] && status_reg_o[0] |=> status_reg_o[5]; endproperty
    a_ehold: assert property (p_ehold) else $error("erase fail flag lost");
    property p_done; s_done |=> status_reg_o[1:0] == 2'h0; endproperty
    a_done: assert property (p_done) else $error("latch or busy kept after done");
    property p_start; op_start_o |-> status_reg_o[1:0] == 2'h3 && $past(status_reg_o[1]); endproperty
    a_start: assert property (p_start) else $error("start without latch or busy");
    property p_lock; hw_protect_o |=> $stable({status_reg_o[7], status_reg_o[4:2]}); endproperty
    a_lock: assert property (p_lock) else $error("locked bits changed");
    property p_wel; status_reg_o[0] |=> !$rose(status_reg_o[1]); endproperty
    a_wel: assert property (p_wel) else $error("latch set while busy");
endmodule : flsp_asserts

// ---- testbench/flsp_host.sv ----
/* flsp_host: serial host model, mode 0, MSB first, 800 ns bit period.
   Assumes it is called at falling edges of the system clock. */
`timescale 1ns/100ps
module flsp_host (
    input  wire logic clk_sys_i,  // system clock
    input  wire logic spi_miso_i, // data from device
    output logic      spi_sclk_o, // serial clock, idle low
    output logic      spi_cs_n_o, // select, active low
    output logic      spi_mosi_o  // data to device
);
    // link idle; clock stands still outside frames
    initial begin
        spi_sclk_o = 1'b0;
        spi_cs_n_o = 1'b1;
        spi_mosi_o = 1'b0;
    end
    // whole bytes of q, then xb stray bits to botch a frame; rx keeps the last byte read
    task automatic frame(input logic [7:0] q[$], input int xb, output logic [7:0] rx);
        spi_cs_n_o = 1'b0;
        for (int i = 0; i < q.size() * 8 + xb; i++) begin
            spi_mosi_o = (i / 8 < q.size()) ? q[i / 8][7 - i % 8] : 1'b1;
            repeat (4) @(negedge clk_sys_i);
            rx = {rx[6:0], spi_miso_i};
            spi_sclk_o = 1'b1;
            repeat (4) @(negedge clk_sys_i);
            spi_sclk_o = 1'b0;
        end
        repeat (4) @(negedge clk_sys_i);
        spi_cs_n_o = 1'b1;
        spi_mosi_o = ~spi_mosi_o; // released line must not keep its last bit
        repeat (8) @(negedge clk_sys_i);
    endtask : frame
endmodule : flsp_host

// ---- testbench/tb.sv ----
/* tb: status block driven through the serial host model and a stub sequencer.
   Assumes the default 128-sector map and a 10 MHz clock. */
`timescale 1ns/100ps
module tb
    import flsp_pkg::*;
;
    logic        clk_sys_i, sys_rst_i, spi_sclk_i, spi_cs_n_i, spi_mosi_i, spi_miso_o;
    logic        wp_n_i, op_done_i, op_fail_i, op_start_o, hw_protect_o, spi_miso_oe_n_o;
    logic [7:0]  status_reg_o;
    logic [23:0] op_addr_o;
    flsp_op_e    op_kind_o;
    int          n_errors = 0, samples_checked = 0, lo;
    flsp_status flsp_status_i (.*);
    flsp_host flsp_host_i (.clk_sys_i, .spi_miso_i(spi_miso_o), .spi_sclk_o(spi_sclk_i),
        .spi_cs_n_o(spi_cs_n_i), .spi_mosi_o(spi_mosi_i));
    // 100 ns system clock
    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    // stub sequencer: slow enough to poll, fails only at sector 5
    always @(posedge clk_sys_i iff op_start_o === 1'b1) begin
        repeat (200) @(negedge clk_sys_i);
        {op_done_i, op_fail_i} = {1'b1, op_addr_o[23:16] == 8'h05};
        @(negedge clk_sys_i);
        {op_done_i, op_fail_i} = 2'b00;
    end
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        if (seen !== exp) n_errors++;
    endtask : chk
    // optional write enable first, then one frame
    task automatic send(input logic [7:0] q[$], input bit we = 0, input int xb = 0);
        logic [7:0] r;
        if (we) flsp_host_i.frame({OPC_WREN}, 0, r);
        flsp_host_i.frame(q, xb, r);
    endtask : send
    // bounded poll until ready, then compare the status byte
    task automatic rd(input logic [7:0] exp);
        logic [7:0] r;
        r = 8'h01;
        for (int i = 0; i < 20 && r[0] !== 1'b0; i++)
            flsp_host_i.frame({OPC_RDSR, 8'h00}, 0, r);
        chk(r, exp);
    endtask : rd
    task automatic stop_test;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    // watchdog well past the expected run of some 14400 cycles
    initial begin
        repeat (90000) @(posedge clk_sys_i);
        n_errors++;
        stop_test();
    end
    // main sequence
    initial begin
        {sys_rst_i, wp_n_i, op_done_i, op_fail_i} = 4'b1100;
        repeat (20) @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        send({OPC_WRSR, 8'h00});
        rd(8'h1c);
        chk(spi_miso_oe_n_o, 1'b1);
        send({OPC_WRSR, 8'he2}, 1);
        chk(status_reg_o, 8'h83);
        rd(8'h80);
        wp_n_i = 1'b0;
        send({OPC_WRSR, 8'h1c}, 1);
        chk(hw_protect_o, 1'b1);
        rd(8'h80);
        send({OPC_SE, 8'h00, 8'h00, 8'h00}, 1, 3);
        rd(8'h82);
        send({OPC_PP, 8'h05, 8'h00, 8'h00, 8'haa});
        chk(op_addr_o, 24'h050000);
        chk(op_kind_o, OP_PAGE);
        send({OPC_CLRF});
        rd(8'hc0);
        send({OPC_PP, 8'h04, 8'h00, 8'h00, 8'haa}, 1);
        rd(8'hc0);
        send({OPC_CLRF}, 1);
        rd(8'h82);
        wp_n_i = 1'b1;
        for (int c = 0; c < 8; c++) begin
            lo = (c == 0) ? 128 : 128 - (1 << c);
            send({OPC_WRSR, 8'(c << 2)}, 1);
            // wait out the status write, else the next write enable is ignored
            rd({3'h0, 3'(c), 2'h0});
            if (c != 0) begin
                send({OPC_SE, 8'(lo), 8'h00, 8'h00}, 1);
                rd({3'h1, 3'(c), 2'h0});
            end
            if (c != 7) begin
                send({OPC_SE, 8'(lo - 1), 8'h00, 8'h00}, 1);
                chk(status_reg_o, {2'h0, c != 0, 3'(c), 2'h3});
                rd({2'h0, c != 0, 3'(c), 2'h0});
            end
            send({OPC_CLRF});
        end
        stop_test();
    end
endmodule : tb
bind flsp_status flsp_asserts flsp_asserts_i (.*);
